// ### iowdt_counter.sv
// Time-out counter of the I/O port watchdog timer
`timescale 1ns/1ns
module iowdt_counter
    import iowdt_pkg::*;
#(
    parameter int LIMIT = IOWDT_TIMEOUT_CYC
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic ce,
    input  wire logic run,
    input  wire logic restart,
    output logic      expired
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    wire           at_last = (count_r == LAST);

    // Restart outranks expiry so a last-cycle refresh still saves the board
    assign expired   = run && at_last && !restart;
    assign count_nxt = (!run || restart || at_last) ? '0
                                                    : count_r + 1'b1;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (ce) begin
            count_r <= count_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    restart_zero_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        ce && restart |=> count_r == '0)
        else $error("refresh did not restart count");

    expire_point_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        expired |-> count_r == LAST && run)
        else $error("expiry at wrong count");

    idle_clear_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        ce && !run |=> count_r == '0 && !expired)
        else $error("count runs while disarmed");

endmodule

// ### iowdt_pkg.sv
// Constants shared by the I/O port watchdog timer
package iowdt_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] IOWDT_CTRL_PORT   = 16'h0455;
    localparam int          IOWDT_ARM_BIT     = 7;
    localparam logic [7:0]  IOWDT_CTRL_RESET  = 8'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int IOWDT_CLK_NS         = 4;
    localparam int IOWDT_TIMEOUT_NS     = 1100000000;
    localparam int IOWDT_TIMEOUT_MIN_NS = 550000000;
    localparam int IOWDT_TIMEOUT_MAX_NS = 1650000000;
    localparam int IOWDT_TIMEOUT_CYC    = IOWDT_TIMEOUT_NS / IOWDT_CLK_NS;
    localparam int IOWDT_MIN_CYC        =
        (IOWDT_TIMEOUT_MIN_NS + IOWDT_CLK_NS - 1) / IOWDT_CLK_NS;
    localparam int IOWDT_MAX_CYC        = IOWDT_TIMEOUT_MAX_NS / IOWDT_CLK_NS;
    localparam int IOWDT_RST_HOLD_CYC   = 8;

endpackage

// ### iowdt_top.sv
// I/O port watchdog timer with its control register
//
// Contract
// - While armed and not refreshed in time, the block asserts module reset.
// - The time-out is nominally 1.1 s and must lie within 550 ms to 1.65 s.
// - With the setup option off the register is absent and no new reset starts; a reset pulse already started still runs its full length.
// - The setup option only makes the timer available; it stays unarmed.
// - Writing one to bit 7 of port 0x455 arms the timer.
// - Writing zero to bit 7 of port 0x455 disarms it; a reset pulse already started still runs its full length.
// - Any read of port 0x455 refreshes the timer and restarts its count.
`timescale 1ns/1ns
module iowdt_top
    import iowdt_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = IOWDT_TIMEOUT_CYC,
    parameter int ADDR_W         = 16
) (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              ce,
    input  wire logic              wdt_setup_en,
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic              io_rd,
    input  wire logic              io_wr,
    input  wire logic [7:0]        io_wdata,
    output logic                   io_hit,
    output logic [7:0]             io_rdata,
    output logic                   io_rdata_valid,
    output logic                   wdt_reset_out
);
    typedef enum logic [1:0] {
        IOWDT_IDLE  = 2'b00,
        IOWDT_ARMED = 2'b01,
        IOWDT_FIRE  = 2'b10
    } iowdt_state_t;

    // ----------------------------------------------------------------
    // Port decode
    // ----------------------------------------------------------------
    // Decode is gated by the setup option so the port simply vanishes
    wire addr_match = (io_addr == ADDR_W'(IOWDT_CTRL_PORT));
    assign io_hit   = wdt_setup_en && addr_match;
    wire rd_hit     = io_hit && io_rd;
    wire wr_hit     = io_hit && io_wr;
    wire wr_arm     = wr_hit && io_wdata[IOWDT_ARM_BIT];
    wire wr_disarm  = wr_hit && !io_wdata[IOWDT_ARM_BIT];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    iowdt_state_t state_r;
    iowdt_state_t state_nxt;
    logic [3:0]   hold_r;
    logic [3:0]   hold_nxt;
    logic         expired;

    wire armed   = (state_r == IOWDT_ARMED);
    wire hold_dn = (hold_r == 4'(IOWDT_RST_HOLD_CYC - 1));

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            IOWDT_IDLE: begin
                if (wr_arm) begin
                    state_nxt = IOWDT_ARMED;
                end
            end
            IOWDT_ARMED: begin
                if (!wdt_setup_en || wr_disarm) begin
                    state_nxt = IOWDT_IDLE;
                end else if (expired) begin
                    state_nxt = IOWDT_FIRE;
                end
            end
            IOWDT_FIRE: begin
                if (hold_dn) begin
                    state_nxt = IOWDT_IDLE;
                end
            end
            default: state_nxt = IOWDT_IDLE;
        endcase
    end

    assign hold_nxt = (state_r == IOWDT_FIRE) ? hold_r + 4'h1 : 4'h0;

    // Comes up disarmed whatever the setup option says
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= IOWDT_IDLE;
            hold_r  <= 4'h0;
        end else if (ce) begin
            state_r <= state_nxt;
            hold_r  <= hold_nxt;
        end
    end

    // Reset output is a clean register so downstream reset logic sees no glitch
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdt_reset_out <= 1'b0;
        end else if (ce) begin
            wdt_reset_out <= (state_nxt == IOWDT_FIRE);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [7:0] ctrl_view = {armed, 7'h00} | IOWDT_CTRL_RESET;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            io_rdata       <= 8'h00;
            io_rdata_valid <= 1'b0;
        end else if (ce) begin
            io_rdata       <= rd_hit ? ctrl_view : 8'h00;
            io_rdata_valid <= rd_hit;
        end
    end

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    // Only a read refreshes; a write of one leaves the running count alone
    iowdt_counter #(
        .LIMIT   (TIMEOUT_CYCLES)
    ) u_counter (
        .clock   (clock),
        .reset_n (reset_n),
        .ce      (ce),
        .run     (armed),
        .restart (rd_hit),
        .expired (expired)
    );

    // ----------------------------------------------------------------
    // Check helpers
    // ----------------------------------------------------------------
    // Own tally of armed cycles since the last arm or refresh, kept
    // apart from the counter module so a wrong limit hook-up shows
    // Only meaningful while armed; it clears the cycle after disarm
    localparam int            QW         = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [QW-1:0] QUIET_LAST = QW'(TIMEOUT_CYCLES - 1);

    logic [QW-1:0] quiet_r;
    logic [QW-1:0] quiet_nxt;
    wire           quiet_run = armed && !rd_hit;

    assign quiet_nxt = quiet_run ? quiet_r + 1'b1 : '0;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            quiet_r <= '0;
        end else if (ce) begin
            quiet_r <= quiet_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    arm_write_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        ce && wr_arm && state_r == IOWDT_IDLE |=> armed)
        else $error("write of one did not arm");

    disarm_write_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        ce && wr_disarm && armed |=> state_r == IOWDT_IDLE ##1 !wdt_reset_out)
        else $error("write of zero did not disarm");

    port_absent_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        ce && !wdt_setup_en |-> !io_hit ##1 !io_rdata_valid)
        else $error("port answers while disabled");

    readback_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        ce && rd_hit |=> io_rdata_valid && io_rdata[7] == $past(armed))
        else $error("arm bit reads back wrong");

    reserved_zero_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        io_rdata_valid |-> io_rdata[6:0] == 7'h00)
        else $error("reserved bits not zero");

    reset_cause_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(wdt_reset_out) |-> $past(expired && ce && armed))
        else $error("reset without time-out");

    reset_hold_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(wdt_reset_out) |-> wdt_reset_out[*8])
        else $error("reset pulse too short");

    timeout_exact_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        expired |-> quiet_r == QUIET_LAST)
        else $error("time-out ends early or late");

    timeout_due_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        quiet_run && quiet_r == QUIET_LAST |-> expired)
        else $error("time-out passed without expiry");

    idle_data_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        !io_rdata_valid |-> io_rdata == 8'h00)
        else $error("read data not zero outside a read");

    idle_quiet_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        ce && state_r == IOWDT_IDLE && !wr_arm |=> state_r == IOWDT_IDLE)
        else $error("armed without a write");

endmodule

// ### test_iowdt_top.sv
// Self-checking bench for the I/O port watchdog timer
`timescale 1ns/1ns
module test_iowdt_top
    import iowdt_pkg::*;
();
    // ------------------------------------------------------------
    // Design and stimulus
    // ------------------------------------------------------------
    localparam int TO = 20;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        ce = 1'b1;
    logic        wdt_setup_en = 1'b1;
    logic [15:0] io_addr = IOWDT_CTRL_PORT;
    logic        io_rd = 1'b0;
    logic        io_wr = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic        io_hit;
    logic [7:0]  io_rdata;
    logic        io_rdata_valid;
    logic        wdt_reset_out;
    int          err_count = 0;
    int          tests_run = 0;
    logic [7:0]  row_wd [3] = '{8'hFF, 8'h7F, 8'h80};
    logic [7:0]  row_rd [3] = '{8'h80, 8'h00, 8'h80};

    iowdt_top #(.TIMEOUT_CYCLES(TO)) u_iowdt_top (
        .clock(clock), .reset_n(reset_n), .ce(ce),
        .wdt_setup_en(wdt_setup_en), .io_addr(io_addr), .io_rd(io_rd),
        .io_wr(io_wr), .io_wdata(io_wdata), .io_hit(io_hit),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .wdt_reset_out(wdt_reset_out));

    always #2 clock = ~clock;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        io_wr = 1'b1;
        io_wdata = d;
        @(posedge clock);
        #1 io_wr = 1'b0;
    endtask

    // Reads take effect only when mapped; ev says whether they should
    task automatic rd(input logic [7:0] e, input logic ev);
        io_rd = 1'b1;
        #1 chk("io_hit", {7'h0, ev}, {7'h0, io_hit});
        @(posedge clock);
        #1 io_rd = 1'b0;
        chk("io_rdata_valid", {7'h0, ev}, {7'h0, io_rdata_valid});
        chk("io_rdata", e, io_rdata);
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock);
            #1 chk("wdt_reset_out", 8'h00, {7'h0, wdt_reset_out});
            chk("io_rdata_valid", 8'h00, {7'h0, io_rdata_valid});
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #20000;
        err_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        #1 chk("io_rdata", 8'h00, io_rdata);
        reset_n = 1'b1;
        rd(8'h00, 1'b1);
        for (int i = 0; i < 3; i++) begin
            wr(row_wd[i]);
            rd(row_rd[i], 1'b1);
        end
        wr(io_rdata & 8'h7F);
        idle(1);
        // Armed and left alone: exact time-out and pulse length
        wr(8'h80);
        idle(TO - 2);
        @(posedge clock);
        #1 chk("wdt_reset_out", 8'h00, {7'h0, wdt_reset_out});
        @(posedge clock);
        #1 chk("wdt_reset_out", 8'h01, {7'h0, wdt_reset_out});
        repeat (IOWDT_RST_HOLD_CYC - 1) @(posedge clock);
        #1 chk("wdt_reset_out", 8'h01, {7'h0, wdt_reset_out});
        idle(1);
        rd(8'h00, 1'b1);
        // Reads just before expiry keep it alive
        wr(8'h80);
        repeat (3) begin
            idle(TO - 3);
            rd(8'h80, 1'b1);
        end
        repeat (2) begin
            idle(TO / 2 - 1);
            rd(8'h80, 1'b1);
        end
        // Clock enable low freezes the count
        idle(TO - 5);
        ce = 1'b0;
        idle(3 * TO);
        ce = 1'b1;
        wr(8'h00);
        idle(2 * TO);
        // Unmapped port is ignored
        io_addr = IOWDT_CTRL_PORT + 16'h0001;
        wr(8'h80);
        rd(8'h00, 1'b0);
        idle(1);
        io_addr = IOWDT_CTRL_PORT;
        rd(8'h00, 1'b1);
        // Setup option off while armed: port absent, timer disarmed
        wr(8'h80);
        wdt_setup_en = 1'b0;
        rd(8'h00, 1'b0);
        wr(8'h80);
        idle(2 * TO);
        wdt_setup_en = 1'b1;
        rd(8'h00, 1'b1);
        // Second reset while armed leaves it disarmed
        wr(8'h80);
        reset_n = 1'b0;
        idle(2);
        reset_n = 1'b1;
        rd(8'h00, 1'b1);
        idle(2 * TO);
        end_of_test();
    end
endmodule
